/* File: core/dtc_pkg.sv */
// constants and types shared by the dual 8-bit timer block
package dtc_pkg;

   // clock rates: core clock and the main system clock it stands in for
   localparam int unsigned CORE_HZ = 25_000_000;
   localparam int unsigned FX_HZ   = 5_000_000;
   localparam int unsigned FX_DIV  = CORE_HZ / FX_HZ;

   // byte addresses of the memory-mapped registers
   localparam logic [15:0] ADDR_COUNTER_A     = 16'hff62;
   localparam logic [15:0] ADDR_COMPARE_A     = 16'hff63;
   localparam logic [15:0] ADDR_COUNTER_A_CTL = 16'hff65;
   localparam logic [15:0] ADDR_COUNTER_B     = 16'hff66;
   localparam logic [15:0] ADDR_COMPARE_B_LO  = 16'hff67;
   localparam logic [15:0] ADDR_COMPARE_B_HI  = 16'hff68;
   localparam logic [15:0] ADDR_COUNTER_B_CTL = 16'hff69;
   localparam logic [15:0] ADDR_CARRIER_CTL   = 16'hff6a;

   // writable bits of the control registers, others read zero
   localparam logic [7:0] CTL_A_MASK   = 8'h9a;
   localparam logic [7:0] CTL_B_MASK   = 8'hbf;
   localparam logic [7:0] CARRIER_MASK = 8'h07;
   localparam logic [7:0] CTL_RESET    = 8'h00;
   localparam logic [7:0] COUNT_RESET  = 8'h00;

   // field positions
   localparam int unsigned CTL_RUN_BIT   = 7;
   localparam int unsigned CTL_A_CLK_LSB = 3;
   localparam int unsigned CTL_A_MODE2   = 1;
   localparam int unsigned CTL_B_CLK_LSB = 3;
   localparam int unsigned CTL_B_MODE1   = 2;
   localparam int unsigned CTL_B_MODE0   = 1;
   localparam int unsigned CTL_B_OE_BIT  = 0;
   localparam int unsigned CAR_RMC_BIT   = 2;
   localparam int unsigned CAR_NRZB_BIT  = 1;
   localparam int unsigned CAR_NRZ_BIT   = 0;

   // prescaler tap indices: fx, /2, /4, /8, /16, /64, /256
   localparam int unsigned TAP_COUNT = 7;
   localparam int unsigned TAP_FX    = 0;
   localparam int unsigned TAP_D2    = 1;
   localparam int unsigned TAP_D4    = 2;
   localparam int unsigned TAP_D8    = 3;
   localparam int unsigned TAP_D16   = 4;
   localparam int unsigned TAP_D64   = 5;
   localparam int unsigned TAP_D256  = 6;

   typedef enum logic [2:0] {
      MODE_DISCRETE = 3'b000,
      MODE_CASCADE  = 3'b101,
      MODE_CARRIER  = 3'b011,
      MODE_PWM      = 3'b010
   } dtc_mode_t;

endpackage

/* File: core/dtc_prescale.sv */
// divider turning the core clock into fx and its binary sub-rates
`timescale 1ns/1ps
`default_nettype none
module dtc_prescale
   import dtc_pkg::*;
#(
   parameter int unsigned DIV = FX_DIV
)
(
   // clock and reset
   input  wire logic                 core_clk_i,
   input  wire logic                 rst_i,
   // one-cycle enables, one per tap
   output logic [TAP_COUNT-1:0]      tick_o
);

   generate
      if (DIV < 1 || DIV > 255)
      begin : g_bad_div
         $error("prescaler divide must be 1 to 255");
      end
   endgenerate

   logic [7:0] div_reg;
   logic [7:0] div_next;
   logic [7:0] pre_reg;
   logic [7:0] pre_next;
   logic       fx_tick;

   assign fx_tick = (div_reg == 8'(DIV - 1));

   always_comb
   begin
      div_next = fx_tick ? 8'h00 : div_reg + 8'h01;
      pre_next = fx_tick ? pre_reg + 8'h01 : pre_reg;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         div_reg <= 8'h00;
         pre_reg <= 8'h00;
      end
      else
      begin
         div_reg <= div_next;
         pre_reg <= pre_next;
      end
   end

   // a tap fires when every lower prescaler bit is one
   assign tick_o[TAP_FX]   = fx_tick;
   assign tick_o[TAP_D2]   = fx_tick && (pre_reg[0] == 1'b1);
   assign tick_o[TAP_D4]   = fx_tick && (pre_reg[1:0] == 2'h3);
   assign tick_o[TAP_D8]   = fx_tick && (pre_reg[2:0] == 3'h7);
   assign tick_o[TAP_D16]  = fx_tick && (pre_reg[3:0] == 4'hf);
   assign tick_o[TAP_D64]  = fx_tick && (pre_reg[5:0] == 6'h3f);
   assign tick_o[TAP_D256] = fx_tick && (pre_reg == 8'hff);

endmodule
`default_nettype wire

/* File: core/dtc_timer_top.sv */
// two 8-bit timers with cascade, carrier and PWM modes
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_top
   import dtc_pkg::*;
#(
   parameter int unsigned CLK_DIV = FX_DIV
)
(
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   // cpu memory access
   input  wire logic [15:0] cpu_addr_i,
   input  wire logic        cpu_wr_i,
   input  wire logic        cpu_rd_i,
   input  wire logic [7:0]  cpu_wdata_i,
   output logic      [7:0]  cpu_rdata_o,
   // interrupt requests
   output logic             counter_a_match_irq_o,
   output logic             counter_b_match_irq_o,
   // shared port pin
   input  wire logic        shared_port_latch_i,
   input  wire logic        shared_port_direction_i,
   output logic             timer_output_pin_o,
   output logic             timer_output_pin_oe_n_o
);

   logic [TAP_COUNT-1:0] tick;

   dtc_prescale #(
      .DIV (CLK_DIV)
   ) u_prescale (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .tick_o     (tick)
   );

   // register state
   logic [7:0] ctl_a_reg;
   logic [7:0] ctl_a_next;
   logic [7:0] ctl_b_reg;
   logic [7:0] ctl_b_next;
   logic [7:0] car_reg;
   logic [7:0] car_next;
   logic [7:0] cmp_a_reg;
   logic [7:0] cmp_a_next;
   logic [7:0] cmp_lo_reg;
   logic [7:0] cmp_lo_next;
   logic [7:0] cmp_hi_reg;
   logic [7:0] cmp_hi_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   // counter state
   logic [7:0] cnt_a_reg;
   logic [7:0] cnt_a_next;
   logic [7:0] cnt_b_reg;
   logic [7:0] cnt_b_next;
   logic       level_reg;
   logic       level_next;
   logic       irq_a_reg;
   logic       irq_a_next;
   logic       irq_b_reg;
   logic       irq_b_next;
   logic       pin_reg;
   logic       pin_next;
   logic       oe_n_reg;
   logic       oe_n_next;

   dtc_mode_t  mode;
   logic       run_a;
   logic       run_b;
   logic       tick_a;
   logic       tick_b;
   logic       b_evt;
   logic       b_rise;
   logic       b_ovf;
   logic       a_evt;
   logic       tout;

   // selects a prescaler tap; prohibited codes give no tick
   function automatic logic pick_b(input logic [2:0] sel,
                                   input logic [TAP_COUNT-1:0] t);
      case (sel)
         3'h0:    pick_b = t[TAP_FX];
         3'h1:    pick_b = t[TAP_D4];
         3'h2:    pick_b = t[TAP_D2];
         3'h3:    pick_b = t[TAP_D4];
         3'h4:    pick_b = t[TAP_D8];
         3'h5:    pick_b = t[TAP_D16];
         default: pick_b = 1'b0;
      endcase
   endfunction

   assign mode  = dtc_mode_t'({ctl_a_reg[CTL_A_MODE2],
                               ctl_b_reg[CTL_B_MODE1],
                               ctl_b_reg[CTL_B_MODE0]});
   assign run_a = ctl_a_reg[CTL_RUN_BIT];
   assign run_b = ctl_b_reg[CTL_RUN_BIT];
   assign tick_b = pick_b(ctl_b_reg[CTL_B_CLK_LSB +: 3], tick);

   // register writes; compare registers take whole bytes
   always_comb
   begin
      ctl_a_next  = ctl_a_reg;
      ctl_b_next  = ctl_b_reg;
      car_next    = car_reg;
      cmp_a_next  = cmp_a_reg;
      cmp_lo_next = cmp_lo_reg;
      cmp_hi_next = cmp_hi_reg;
      if (cpu_wr_i)
      begin
         case (cpu_addr_i)
            ADDR_COUNTER_A_CTL: ctl_a_next  = cpu_wdata_i & CTL_A_MASK;
            ADDR_COUNTER_B_CTL: ctl_b_next  = cpu_wdata_i & CTL_B_MASK;
            ADDR_CARRIER_CTL:   car_next    = cpu_wdata_i & CARRIER_MASK;
            ADDR_COMPARE_A:     cmp_a_next  = cpu_wdata_i;
            ADDR_COMPARE_B_LO:  cmp_lo_next = cpu_wdata_i;
            ADDR_COMPARE_B_HI:  cmp_hi_next = cpu_wdata_i;
            default:            ;
         endcase
      end
      // nrz takes its buffered value on each counter A match
      if (a_evt)
      begin
         car_next[CAR_NRZ_BIT] = car_next[CAR_NRZB_BIT];
      end
      rdata_next = rdata_reg;
      if (cpu_rd_i)
      begin
         case (cpu_addr_i)
            ADDR_COUNTER_A:     rdata_next = cnt_a_reg;
            ADDR_COUNTER_B:     rdata_next = cnt_b_reg;
            ADDR_COMPARE_A:     rdata_next = cmp_a_reg;
            ADDR_COMPARE_B_LO:  rdata_next = cmp_lo_reg;
            ADDR_COMPARE_B_HI:  rdata_next = cmp_hi_reg;
            ADDR_COUNTER_A_CTL: rdata_next = ctl_a_reg;
            ADDR_COUNTER_B_CTL: rdata_next = ctl_b_reg;
            ADDR_CARRIER_CTL:   rdata_next = car_reg;
            default:            rdata_next = 8'h00;
         endcase
      end
   end

   // counters and output level
   always_comb
   begin
      cnt_a_next = cnt_a_reg;
      cnt_b_next = cnt_b_reg;
      level_next = level_reg;
      irq_a_next = 1'b0;
      irq_b_next = 1'b0;
      b_evt      = 1'b0;
      b_rise     = 1'b0;
      b_ovf      = tick_b && (cnt_b_reg == 8'hff);
      a_evt      = 1'b0;
      tick_a     = 1'b0;
      case (mode)
         MODE_CASCADE:
         begin
            // B's run bit controls both, A's ignored
            if (!run_b)
            begin
               cnt_a_next = COUNT_RESET;
               cnt_b_next = COUNT_RESET;
               level_next = 1'b0;
            end
            else if (tick_b)
            begin
               // double match clears both; only B's irq
               if (cnt_a_reg == cmp_a_reg && cnt_b_reg == cmp_lo_reg)
               begin
                  cnt_a_next = COUNT_RESET;
                  cnt_b_next = COUNT_RESET;
                  irq_b_next = 1'b1;
                  level_next = !level_reg;
               end
               else
               begin
                  cnt_b_next = cnt_b_reg + 8'h01;
                  // A counts on B's carry out
                  if (b_ovf)
                  begin
                     cnt_a_next = cnt_a_reg + 8'h01;
                  end
               end
            end
         end
         MODE_CARRIER, MODE_PWM:
         begin
            // stopped: clear, next phase is high
            if (!run_b)
            begin
               cnt_b_next = COUNT_RESET;
               level_next = 1'b1;
            end
            else if (tick_b)
            begin
               if (level_reg ? (cnt_b_reg == cmp_hi_reg)
                             : (cnt_b_reg == cmp_lo_reg))
               begin
                  cnt_b_next = COUNT_RESET;
                  level_next = !level_reg;
                  b_evt      = 1'b1;
                  b_rise     = !level_reg;
                  irq_b_next = 1'b1;
               end
               else
               begin
                  cnt_b_next = cnt_b_reg + 8'h01;
               end
            end
         end
         default:
         begin
            // discrete B clears on stop, match, overflow
            if (!run_b)
            begin
               cnt_b_next = COUNT_RESET;
               level_next = 1'b0;
            end
            else if (tick_b)
            begin
               if (cnt_b_reg == cmp_lo_reg)
               begin
                  cnt_b_next = COUNT_RESET;
                  b_evt      = 1'b1;
                  irq_b_next = 1'b1;
                  level_next = !level_reg;
               end
               else
               begin
                  cnt_b_next = cnt_b_reg + 8'h01;
               end
            end
         end
      endcase
      // counter A as its own interval timer outside cascade
      if (mode != MODE_CASCADE)
      begin
         case (ctl_a_reg[CTL_A_CLK_LSB +: 2])
            2'h0:    tick_a = tick[TAP_D64];
            2'h1:    tick_a = tick[TAP_D256];
            2'h2:    tick_a = b_evt;
            default: tick_a = b_rise;
         endcase
         // discrete A clears on stop, match, overflow
         if (!run_a)
         begin
            cnt_a_next = COUNT_RESET;
         end
         else if (tick_a)
         begin
            if (cnt_a_reg == cmp_a_reg)
            begin
               cnt_a_next = COUNT_RESET;
               a_evt      = 1'b1;
               irq_a_next = 1'b1;
            end
            else
            begin
               cnt_a_next = cnt_a_reg + 8'h01;
            end
         end
      end
   end

   // carrier gated by nrz; PWM level straight out
   assign tout = (mode == MODE_CARRIER)
                 ? (car_reg[CAR_NRZ_BIT] &&
                    (car_reg[CAR_RMC_BIT] || level_reg))
                 : level_reg;

   always_comb
   begin
      // port latch on the pin while timer output is off
      pin_next  = ctl_b_reg[CTL_B_OE_BIT] ? tout : shared_port_latch_i;
      oe_n_next = shared_port_direction_i;
   end

   always_ff @(posedge core_clk_i)
   begin
      cmp_a_reg  <= cmp_a_next;
      cmp_lo_reg <= cmp_lo_next;
      cmp_hi_reg <= cmp_hi_next;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         ctl_a_reg <= CTL_RESET;
         ctl_b_reg <= CTL_RESET;
         car_reg   <= CTL_RESET;
         rdata_reg <= 8'h00;
         cnt_a_reg <= COUNT_RESET;
         cnt_b_reg <= COUNT_RESET;
         level_reg <= 1'b0;
         irq_a_reg <= 1'b0;
         irq_b_reg <= 1'b0;
         pin_reg   <= 1'b0;
         oe_n_reg  <= 1'b1;
      end
      else
      begin
         ctl_a_reg <= ctl_a_next;
         ctl_b_reg <= ctl_b_next;
         car_reg   <= car_next;
         rdata_reg <= rdata_next;
         cnt_a_reg <= cnt_a_next;
         cnt_b_reg <= cnt_b_next;
         level_reg <= level_next;
         irq_a_reg <= irq_a_next;
         irq_b_reg <= irq_b_next;
         pin_reg   <= pin_next;
         oe_n_reg  <= oe_n_next;
      end
   end

   assign cpu_rdata_o             = rdata_reg;
   assign counter_a_match_irq_o   = irq_a_reg;
   assign counter_b_match_irq_o   = irq_b_reg;
   assign timer_output_pin_o      = pin_reg;
   assign timer_output_pin_oe_n_o = oe_n_reg;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_a_match;
      mode != MODE_CASCADE && run_a && tick_a && cnt_a_reg == cmp_a_reg;
   endsequence
   sequence s_a_cleared;
      counter_a_match_irq_o && cnt_a_reg == 8'h00;
   endsequence
   sequence s_hi_match;
      (mode == MODE_PWM || mode == MODE_CARRIER) && run_b && tick_b
      && level_reg && cnt_b_reg == cmp_hi_reg;
   endsequence

   property p_a_match;
      s_a_match |=> s_a_cleared;
   endproperty
   a_a_match: assert property (p_a_match)
      else $error("counter A match did not clear and interrupt");

   property p_b_match;
      mode == MODE_DISCRETE && run_b && tick_b && cnt_b_reg == cmp_lo_reg
      |=> counter_b_match_irq_o && cnt_b_reg == 8'h00;
   endproperty
   a_b_match: assert property (p_b_match)
      else $error("counter B match did not clear and interrupt");

   property p_casc_no_a_irq;
      mode == MODE_CASCADE && $past(mode) == MODE_CASCADE
      |-> !counter_a_match_irq_o;
   endproperty
   a_casc_no_a_irq: assert property (p_casc_no_a_irq)
      else $error("counter A interrupt raised in cascade mode");

   property p_casc_stop;
      mode == MODE_CASCADE && !run_b
      |=> cnt_a_reg == 8'h00 && cnt_b_reg == 8'h00;
   endproperty
   a_casc_stop: assert property (p_casc_stop)
      else $error("cascade stop did not clear both counters");

   property p_casc_hold;
      mode == MODE_CASCADE && run_b && tick_b && cnt_b_reg != 8'hff
      && !(cnt_a_reg == cmp_a_reg && cnt_b_reg == cmp_lo_reg)
      |=> $stable(cnt_a_reg) && cnt_b_reg == $past(cnt_b_reg) + 8'h01;
   endproperty
   a_casc_hold: assert property (p_casc_hold)
      else $error("counter A moved without counter B carry");

   property p_hi_toggle;
      s_hi_match |=> !level_reg && counter_b_match_irq_o
                     && cnt_b_reg == 8'h00;
   endproperty
   a_hi_toggle: assert property (p_hi_toggle)
      else $error("high-width match did not end the high phase");

   property p_port_pin;
      !ctl_b_reg[CTL_B_OE_BIT] |=> timer_output_pin_o
                                   == $past(shared_port_latch_i);
   endproperty
   a_port_pin: assert property (p_port_pin)
      else $error("pin did not follow the port latch");

   property p_discrete_out;
      mode == MODE_DISCRETE && ctl_b_reg[CTL_B_OE_BIT]
      |=> timer_output_pin_o == $past(level_reg);
   endproperty
   a_discrete_out: assert property (p_discrete_out)
      else $error("discrete output is not counter B's square wave");

   property p_a_stop;
      mode != MODE_CASCADE && !run_a |=> cnt_a_reg == 8'h00;
   endproperty
   a_a_stop: assert property (p_a_stop)
      else $error("counter A not cleared while stopped");

endmodule
`default_nettype wire

/* File: tb/dtc_load_model.sv */
// external load on the shared timer pin, measures level run lengths
`timescale 1ns/1ps
`default_nettype none
module dtc_load_model
(
   // clock and reset
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   // pin as the load sees it
   input  wire logic pin_i,
   input  wire logic pin_oe_n_i,
   // measured lengths in cycles, and the count of rises
   output var int    high_len_o,
   output var int    low_len_o,
   output var int    rises_o
);
   logic lvl;
   logic last_reg;
   int   run_reg;
   assign lvl = pin_oe_n_i ? 1'b1 : pin_i;
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         last_reg   <= lvl;
         run_reg    <= 1;
         high_len_o <= 0;
         low_len_o  <= 0;
         rises_o    <= 0;
      end
      else if (lvl !== last_reg)
      begin
         if (last_reg)
            high_len_o <= run_reg;
         else
            low_len_o <= run_reg;
         if (lvl)
            rises_o <= rises_o + 1;
         run_reg  <= 1;
         last_reg <= lvl;
      end
      else
         run_reg <= run_reg + 1;
   end
endmodule
`default_nettype wire

/* File: tb/dtc_timer_top_test.sv */
// self-checking bench for the dual 8-bit timer block
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_top_test;
   import dtc_pkg::*;
   logic        clk;
   logic        rst;
   logic [15:0] addr;
   logic        cpu_wr;
   logic        cpu_rd;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   logic        irq_a;
   logic        irq_b;
   logic        latch;
   logic        dir;
   logic        pin;
   logic        oe_n;
   int          hi;
   int          lo;
   int          rises;
   int          fails = 0;
   int          tests_run = 0;
   int          cyc = 0;
   int          na = 0;

   dtc_timer_top #(.CLK_DIV(1)) dtc_timer_top_i (
      .core_clk_i(clk), .rst_i(rst), .cpu_addr_i(addr), .cpu_wr_i(cpu_wr),
      .cpu_rd_i(cpu_rd), .cpu_wdata_i(wdata), .cpu_rdata_o(rdata),
      .counter_a_match_irq_o(irq_a), .counter_b_match_irq_o(irq_b),
      .shared_port_latch_i(latch), .shared_port_direction_i(dir),
      .timer_output_pin_o(pin), .timer_output_pin_oe_n_o(oe_n));

   dtc_load_model dtc_load_model_i (
      .core_clk_i(clk), .rst_i(rst), .pin_i(pin), .pin_oe_n_i(oe_n),
      .high_len_o(hi), .low_len_o(lo), .rises_o(rises));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (irq_a === 1'b1)
         na <= na + 1;
   end

   task check(input logic [31:0] got, input logic [31:0] exp, string msg);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: %s got %0h", $time, msg, got);
      end
   endtask

   task bus_wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      cpu_wr = 1'b1;
      @(negedge clk);
      cpu_wr = 1'b0;
   endtask

   task bus_rd(input logic [15:0] a, output logic [7:0] d);
      @(negedge clk);
      addr = a;
      cpu_rd = 1'b1;
      @(negedge clk);
      cpu_rd = 1'b0;
      d = rdata;
   endtask

   task wait_pulse(input bit sel_a, output int at);
      int n;
      n = 0;
      @(negedge clk);
      while (((sel_a ? irq_a : irq_b) !== 1'b1) && n < 600)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 600)
      begin
         fails++;
         $display("wrong value at %0t: no interrupt pulse", $time);
      end
      at = cyc;
   endtask

   task test_reset();
      logic [15:0] a [6];
      logic [7:0]  d;
      a = '{ADDR_COUNTER_A, ADDR_COUNTER_A_CTL, ADDR_COUNTER_B,
             ADDR_COUNTER_B_CTL, ADDR_CARRIER_CTL, 16'hff64};
      check(oe_n, 1'b1, "oe after reset");
      bus_wr(ADDR_COUNTER_A, 8'h55);
      bus_wr(ADDR_COUNTER_A_CTL, 8'h65);
      foreach (a[i])
      begin
         bus_rd(a[i], d);
         check(d, 8'h00, "reset or refused read");
      end
   endtask

   task test_discrete_b();
      int t0;
      int t1;
      logic [7:0] d;
      dir = 1'b0;
      bus_wr(ADDR_COMPARE_B_LO, 8'h03);
      bus_wr(ADDR_COUNTER_B_CTL, 8'h81);
      wait_pulse(0, t0);
      wait_pulse(0, t1);
      check(t1 - t0, 4, "b interval");
      repeat (20) @(negedge clk);
      check(hi, 4, "b square high");
      check(lo, 4, "b square low");
      bus_wr(ADDR_COUNTER_B_CTL, 8'h01);
      bus_rd(ADDR_COUNTER_B, d);
      check(d, 8'h00, "b cleared on stop");
   endtask

   task test_discrete_a();
      int t0;
      int t1;
      int r0;
      logic [7:0] d;
      r0 = rises;
      bus_wr(ADDR_COMPARE_A, 8'h02);
      bus_wr(ADDR_COUNTER_A_CTL, 8'h80);
      wait_pulse(1, t0);
      wait_pulse(1, t1);
      check(t1 - t0, 192, "a interval");
      check(rises, r0, "a has no output");
      bus_wr(ADDR_COUNTER_A_CTL, 8'h00);
      bus_rd(ADDR_COUNTER_A, d);
      check(d, 8'h00, "a cleared on stop");
   endtask

   task test_cascade();
      int t0;
      int t1;
      int na0;
      logic [7:0] d;
      bus_wr(ADDR_COMPARE_A, 8'h01);
      bus_wr(ADDR_COMPARE_B_LO, 8'h02);
      bus_wr(ADDR_COUNTER_A_CTL, 8'h02);
      na0 = na;
      bus_wr(ADDR_COUNTER_B_CTL, 8'h83);
      wait_pulse(0, t0);
      wait_pulse(0, t1);
      check(t1 - t0, 259, "16-bit interval");
      check(na, na0, "no a irq in cascade");
      // the load sees the pin change two edges after the match
      repeat (3) @(negedge clk);
      check(hi, 259, "16-bit square");
      // read lands on the 257th count after the clear: A=1, B=1
      repeat (253) @(negedge clk);
      bus_rd(ADDR_COUNTER_A, d);
      check(d, 8'h01, "a carried from b");
      bus_wr(ADDR_COUNTER_B_CTL, 8'h03);
      bus_rd(ADDR_COUNTER_A, d);
      check(d, 8'h00, "a cleared by b stop");
      bus_wr(ADDR_COUNTER_B_CTL, 8'h00);
      bus_wr(ADDR_COUNTER_A_CTL, 8'h00);
   endtask

   // compare A is left untouched here, counter A still matches against it in PWM mode when running
   task test_pwm(input logic [7:0] ctlb);
      int t0;
      int t1;
      int t2;
      bus_wr(ADDR_COMPARE_B_HI, 8'h02);
      bus_wr(ADDR_COMPARE_B_LO, 8'h04);
      bus_wr(ADDR_COUNTER_B_CTL, ctlb);
      wait_pulse(0, t0);
      wait_pulse(0, t1);
      wait_pulse(0, t2);
      check(t2 - t0, 8, "both widths raise b irq");
      repeat (30) @(negedge clk);
      check(hi, 3, "high width");
      check(lo, 5, "low width");
   endtask

   task test_carrier_gate();
      int r0;
      bus_wr(ADDR_CARRIER_CTL, 8'h01);
      test_pwm(8'h87);
      bus_wr(ADDR_CARRIER_CTL, 8'h00);
      repeat (3) @(negedge clk);
      r0 = rises;
      repeat (20) @(negedge clk);
      check(pin, 1'b0, "carrier gated off");
      check(rises, r0, "no carrier pulses");
      bus_wr(ADDR_COUNTER_B_CTL, 8'h00);
   endtask

   // counter A ticks on each low to high step and reloads nrz
   task test_carrier_a();
      int r0;
      bus_wr(ADDR_COMPARE_A, 8'h00);
      bus_wr(ADDR_CARRIER_CTL, 8'h02);
      bus_wr(ADDR_COUNTER_A_CTL, 8'h98);
      test_pwm(8'h87);
      // remote level select: a steady high once nrz is reloaded
      bus_wr(ADDR_CARRIER_CTL, 8'h06);
      repeat (12) @(negedge clk);
      r0 = rises;
      repeat (20) @(negedge clk);
      check(pin, 1'b1, "remote level high");
      check(rises, r0, "remote level steady");
      bus_wr(ADDR_COUNTER_A_CTL, 8'h00);
      bus_wr(ADDR_COUNTER_B_CTL, 8'h00);
      bus_wr(ADDR_CARRIER_CTL, 8'h00);
   endtask

   task test_port();
      for (int v = 0; v < 2; v++)
      begin
         latch = v[0];
         repeat (2) @(negedge clk);
         check(pin, v[0], "pin follows latch");
      end
      dir = 1'b1;
      repeat (2) @(negedge clk);
      check(oe_n, 1'b1, "pin released");
   endtask

   task print_verdict();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      $display("wrong value at %0t: watchdog ran out", $time);
      print_verdict();
   end

   initial
   begin
      rst = 1'b1;
      addr = 16'h0000;
      cpu_wr = 1'b0;
      cpu_rd = 1'b0;
      wdata = 8'h00;
      latch = 1'b0;
      dir = 1'b1;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      test_reset();
      test_discrete_b();
      test_discrete_a();
      test_cascade();
      test_pwm(8'h85);
      bus_wr(ADDR_COUNTER_B_CTL, 8'h00);
      test_carrier_gate();
      test_carrier_a();
      test_port();
      print_verdict();
   end
endmodule
`default_nettype wire
